// ### logic/acb_bank.sv
// Alarm and sensor correction configuration bank with Wishbone access
`timescale 1ns/100ps
// Operation
// - Process alarm output enable: 0 enables, 1 disables; resets to disabled.
// - Rising commit request applies settings only while all channels are stopped.
// - Process alarm limit outside channel range raises error code 0008H.
// - Limits must satisfy lower-lower <= lower-upper <= upper-lower <= upper-upper.
// - Temperature values are whole degrees at decimal 0, tenths at decimal 1.
// - Process alarm limit defaults depend on the model variant.
// - Rate alarm output enable: 0 enables, 1 disables; resets to disabled.
// - Rate alarm period counts sampling cycles, 1 to 6000, default 1.
// - Rate alarm limits accept any signed 16-bit value, default 0.
// - One-point trim accepted from -5000 to 5000, default 0.
// - Trim applies only when correction function select is 0.
// - Rising live change request commits the trim during operation.
// - Offset point measured value stored, times ten at decimal 1.
// - Gain point measured value stored, scaled the same way.
// - Two-point target values must lie in channel range, default 0.
// - Rejected setting raises error flag and loads latest error word.
// - Out-of-range committed setting keeps its previous active value.
module acb_bank
	import acb_pkg::*;
#(
	parameter bit WIDE_VARIANT = 1'b0
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire acb_wb_req_t        wb_i,
	output wire acb_wb_rsp_t        wb_o,
	input  wire logic [NCH-1:0]     ch_run,
	input  wire acb_meas_t          meas_i,
	output wire acb_ch_t [NCH-1:0]  act_o,
	output wire logic               trim_on_o,
	output wire logic               irq_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	acb_state_t         s_ff;
	acb_state_t         nxt_s;
	logic               hit;
	logic               wr;
	logic               cmt;
	logic               live;
	logic               e4;
	logic               e8;
	logic [9:0]         idx;
	logic [9:0]         pb;
	logic [9:0]         tb;
	logic [15:0]        rd;
	logic signed [15:0] scaled;
	acb_ch_t            pc;

	assign wb_o      = '{ack: s_ff.ack, dat: {16'h0000, s_ff.rdat}};
	assign act_o     = s_ff.act;
	assign trim_on_o = s_ff.trim_on;
	assign irq_o     = s_ff.irq;

	// Byte-lane merge of bus write data into a 16-bit word
	function automatic logic [15:0] wm(input logic [15:0] o);
		return {wb_i.sel[1] ? wb_i.dat[15:8] : o[15:8], wb_i.sel[0] ? wb_i.dat[7:0] : o[7:0]};
	endfunction : wm

	function automatic logic wb1(input logic o);
		return wb_i.sel[0] ? wb_i.dat[0] : o;
	endfunction : wb1

	// Range limits are kept in whole degrees and scaled to the channel unit
	function automatic logic in_rng(input logic signed [15:0] v, input acb_rng_t r);
		logic signed [19:0] lo;
		logic signed [19:0] hi;
		lo = r.dp ? 20'(r.lo) * 20'(DP_MUL) : 20'(r.lo);
		hi = r.dp ? 20'(r.hi) * 20'(DP_MUL) : 20'(r.hi);
		return (20'(v) >= lo) && (20'(v) <= hi);
	endfunction : in_rng

	function automatic acb_state_t rst_val();
		acb_state_t v;
		v = '0;
		for (int c = 0; c < NCH; c++) begin
			v.pend[c].pa_en  = PA_EN_RST;
			v.pend[c].ll     = WIDE_VARIANT ? PA_LOW_RST_B : PA_LOW_RST_A;
			v.pend[c].lu     = WIDE_VARIANT ? PA_LOW_RST_B : PA_LOW_RST_A;
			v.pend[c].ul     = WIDE_VARIANT ? PA_HIGH_RST_B : PA_HIGH_RST_A;
			v.pend[c].uu     = WIDE_VARIANT ? PA_HIGH_RST_B : PA_HIGH_RST_A;
			v.pend[c].ra_en  = RA_EN_RST;
			v.pend[c].ra_per = RA_PERIOD_RST;
			v.rng[c].lo      = RANGE_LOW_RST;
			v.rng[c].hi      = RANGE_HIGH_RST;
		end
		v.act     = v.pend;
		v.trim_on = 1'b1;
		return v;
	endfunction : rst_val

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_s      = s_ff;
		hit        = wb_i.cyc & wb_i.stb & ~s_ff.ack;
		wr         = hit & wb_i.we;
		idx        = wb_i.adr[11:2];
		rd         = 16'h0000;
		pb         = 10'h000;
		tb         = 10'h000;
		e4         = 1'b0;
		e8         = 1'b0;
		pc         = s_ff.pend[0];
		scaled     = meas_i.process_value;
		cmt        = s_ff.ctrl[CTRL_COMMIT] & ~s_ff.ctrl_d[CTRL_COMMIT];
		live       = s_ff.ctrl[CTRL_LIVE] & ~s_ff.ctrl_d[CTRL_LIVE];
		nxt_s.ctrl_d = s_ff.ctrl;
		nxt_s.ack  = hit;

		// Fixed registers; unmapped addresses answer with zero data
		case (idx)
			IX_CTRL: begin
				rd = {14'h0000, s_ff.ctrl};
				if (wr) nxt_s.ctrl = 2'(wm(rd));
			end
			IX_RUN:          rd = {12'h000, ch_run};
			IX_CORR_FUNC: begin
				rd = {12'h000, s_ff.func};
				if (wr) nxt_s.func = 4'(wm(rd));
			end
			IX_LATEST_ERROR: rd = s_ff.err;
			IX_IRQ_STATUS:   rd = {13'h0000, s_ff.ist};
			IX_IRQ_CLEAR: begin
				if (wr) nxt_s.ist = s_ff.ist & ~wb_i.dat[NIRQ-1:0];
			end
			IX_IRQ_ENABLE: begin
				rd = {13'h0000, s_ff.ien};
				if (wr) nxt_s.ien = NIRQ'(wm(rd));
			end
			IX_DECIMAL: begin
				for (int c = 0; c < NCH; c++) begin
					rd[c] = s_ff.rng[c].dp;
					if (wr && wb_i.sel[0]) nxt_s.rng[c].dp = wb_i.dat[c];
				end
			end
			default: rd = 16'h0000;
		endcase

		// Per-channel words at fixed strides
		for (int c = 0; c < NCH; c++) begin
			pb = IX_PROC_ALARM_ENABLE_CH1 + 10'(c) * IX_ALARM_STRIDE;
			tb = 10'(c) * IX_TWO_POINT_STRIDE;
			if (idx == pb) begin
				rd = {15'h0000, s_ff.pend[c].pa_en};
				if (wr) nxt_s.pend[c].pa_en = wb1(rd[0]);
			end
			if (idx == pb + IX_PROC_ALARM_LOWER_LOWER - IX_PROC_ALARM_ENABLE_CH1) begin
				rd = s_ff.pend[c].ll;
				if (wr) nxt_s.pend[c].ll = wm(rd);
			end
			if (idx == pb + IX_PROC_ALARM_LOWER_UPPER - IX_PROC_ALARM_ENABLE_CH1) begin
				rd = s_ff.pend[c].lu;
				if (wr) nxt_s.pend[c].lu = wm(rd);
			end
			if (idx == pb + IX_PROC_ALARM_UPPER_LOWER - IX_PROC_ALARM_ENABLE_CH1) begin
				rd = s_ff.pend[c].ul;
				if (wr) nxt_s.pend[c].ul = wm(rd);
			end
			if (idx == pb + IX_PROC_ALARM_UPPER_UPPER - IX_PROC_ALARM_ENABLE_CH1) begin
				rd = s_ff.pend[c].uu;
				if (wr) nxt_s.pend[c].uu = wm(rd);
			end
			if (idx == pb + IX_RATE_ALARM_ENABLE - IX_PROC_ALARM_ENABLE_CH1) begin
				rd = {15'h0000, s_ff.pend[c].ra_en};
				if (wr) nxt_s.pend[c].ra_en = wb1(rd[0]);
			end
			if (idx == pb + IX_RATE_ALARM_PERIOD - IX_PROC_ALARM_ENABLE_CH1) begin
				rd = s_ff.pend[c].ra_per;
				if (wr) nxt_s.pend[c].ra_per = wm(rd);
			end
			if (idx == pb + IX_RATE_ALARM_UPPER - IX_PROC_ALARM_ENABLE_CH1) begin
				rd = s_ff.pend[c].ra_up;
				if (wr) nxt_s.pend[c].ra_up = wm(rd);
			end
			if (idx == pb + IX_RATE_ALARM_LOWER - IX_PROC_ALARM_ENABLE_CH1) begin
				rd = s_ff.pend[c].ra_lo;
				if (wr) nxt_s.pend[c].ra_lo = wm(rd);
			end
			if (idx == IX_SENSOR_OFFSET_TRIM + 10'(c)) begin
				rd = s_ff.pend[c].trim;
				if (wr) nxt_s.pend[c].trim = wm(rd);
			end
			if (idx == IX_TWO_POINT_OFFSET_MEASURED + tb) rd = s_ff.pend[c].off_meas;
			if (idx == IX_TWO_POINT_GAIN_MEASURED + tb)   rd = s_ff.pend[c].gain_meas;
			if (idx == IX_TWO_POINT_OFFSET_TARGET + tb) begin
				rd = s_ff.pend[c].off_tgt;
				if (wr) nxt_s.pend[c].off_tgt = wm(rd);
			end
			if (idx == IX_TWO_POINT_GAIN_TARGET + tb) begin
				rd = s_ff.pend[c].gain_tgt;
				if (wr) nxt_s.pend[c].gain_tgt = wm(rd);
			end
			if (idx == IX_RANGE_LOW + 10'(c)) begin
				rd = s_ff.rng[c].lo;
				if (wr) nxt_s.rng[c].lo = wm(rd);
			end
			if (idx == IX_RANGE_HIGH + 10'(c)) begin
				rd = s_ff.rng[c].hi;
				if (wr) nxt_s.rng[c].hi = wm(rd);
			end
		end
		nxt_s.rdat = hit ? rd : s_ff.rdat;

		// Measured temperature at the two correction points
		scaled = s_ff.rng[meas_i.ch].dp ? 16'(meas_i.process_value * DP_MUL) : meas_i.process_value;
		if (meas_i.cap_off) nxt_s.pend[meas_i.ch].off_meas = scaled;
		if (meas_i.cap_gain) nxt_s.pend[meas_i.ch].gain_meas = scaled;

		// Commit; a running channel blocks the whole commit
		if (cmt && (|ch_run)) begin
			nxt_s.ist[IRQ_REFUSED] = 1'b1;
		end else if (cmt) begin
			for (int c = 0; c < NCH; c++) begin
				pc = s_ff.pend[c];
				nxt_s.act[c].pa_en     = pc.pa_en;
				nxt_s.act[c].ra_en     = pc.ra_en;
				nxt_s.act[c].ra_up     = pc.ra_up;
				nxt_s.act[c].ra_lo     = pc.ra_lo;
				nxt_s.act[c].off_meas  = pc.off_meas;
				nxt_s.act[c].gain_meas = pc.gain_meas;
				if (in_rng(pc.ll, s_ff.rng[c]) && in_rng(pc.lu, s_ff.rng[c]) && in_rng(pc.ul, s_ff.rng[c]) &&
					in_rng(pc.uu, s_ff.rng[c]) && pc.ll <= pc.lu && pc.lu <= pc.ul && pc.ul <= pc.uu) begin
					nxt_s.act[c].ll = pc.ll;
					nxt_s.act[c].lu = pc.lu;
					nxt_s.act[c].ul = pc.ul;
					nxt_s.act[c].uu = pc.uu;
				end else begin
					e8 = 1'b1;
				end
				if (pc.ra_per >= RA_PERIOD_MIN && pc.ra_per <= RA_PERIOD_MAX) nxt_s.act[c].ra_per = pc.ra_per;
				else e4 = 1'b1;
				if (pc.trim >= TRIM_MIN && pc.trim <= TRIM_MAX) nxt_s.act[c].trim = pc.trim;
				else e4 = 1'b1;
				if (in_rng(pc.off_tgt, s_ff.rng[c])) nxt_s.act[c].off_tgt = pc.off_tgt;
				else e4 = 1'b1;
				if (in_rng(pc.gain_tgt, s_ff.rng[c])) nxt_s.act[c].gain_tgt = pc.gain_tgt;
				else e4 = 1'b1;
			end
			nxt_s.ist[IRQ_DONE] = 1'b1;
		end

		// Live change touches only the one-point trim
		if (live) begin
			for (int c = 0; c < NCH; c++) begin
				if (s_ff.pend[c].trim >= TRIM_MIN && s_ff.pend[c].trim <= TRIM_MAX) begin
					nxt_s.act[c].trim = s_ff.pend[c].trim;
				end else begin
					e4 = 1'b1;
				end
			end
			nxt_s.ist[IRQ_DONE] = 1'b1;
		end

		// Events set after the bus clear so a same-cycle event is kept
		if (e4) nxt_s.err = ERR_WRITE_DATA;
		if (e8) nxt_s.err = ERR_OUT_OF_RANGE;
		if (e4 || e8) nxt_s.ist[IRQ_ERROR] = 1'b1;
		nxt_s.trim_on = (s_ff.func == FUNC_ONE_POINT);
		nxt_s.irq     = |(nxt_s.ist & nxt_s.ien);
	end

	always_ff @(posedge clk) begin
		if (rst) s_ff <= rst_val();
		else s_ff <= nxt_s;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_PA_EN_RST: assert property (@(posedge clk)
		$fell(rst) |-> s_ff.act[0].pa_en && s_ff.pend[3].pa_en)
		else $error("process alarm enable not disabled after reset");
	AST_RA_EN_RST: assert property (@(posedge clk)
		$fell(rst) |-> s_ff.act[2].ra_en && s_ff.act[0].ra_per == 16'h0001)
		else $error("rate alarm defaults wrong after reset");
	AST_RUN_HOLD: assert property (@(posedge clk) disable iff (rst)
		cmt && (|ch_run) && !live |=> s_ff.act == $past(s_ff.act))
		else $error("commit changed settings while running");
	AST_REFUSED: assert property (@(posedge clk) disable iff (rst)
		cmt && (|ch_run) |=> s_ff.ist[IRQ_REFUSED])
		else $error("refused commit not flagged");
	AST_DONE: assert property (@(posedge clk) disable iff (rst)
		cmt && !(|ch_run) |=> s_ff.ist[IRQ_DONE])
		else $error("accepted commit not flagged");
	AST_ORDER_ERR: assert property (@(posedge clk) disable iff (rst)
		cmt && !(|ch_run) && s_ff.pend[2].ul < s_ff.pend[2].lu |=> s_ff.err == 16'h0008 && s_ff.ist[0])
		else $error("unordered limits not flagged");
	AST_LIMIT_KEEP: assert property (@(posedge clk) disable iff (rst)
		cmt && !(|ch_run) && s_ff.pend[2].ul < s_ff.pend[2].lu |=> s_ff.act[2].lu == $past(s_ff.act[2].lu))
		else $error("unordered limits were applied");
	AST_RANGE_ERR: assert property (@(posedge clk) disable iff (rst)
		cmt && !(|ch_run) && !s_ff.rng[2].dp && s_ff.pend[2].uu > s_ff.rng[2].hi |=> s_ff.err == ERR_OUT_OF_RANGE)
		else $error("limit outside channel range not flagged");
	AST_ACT_ORDER: assert property (@(posedge clk) disable iff (rst)
		s_ff.act[2].ll <= s_ff.act[2].lu && s_ff.act[2].lu <= s_ff.act[2].ul && s_ff.act[2].ul <= s_ff.act[2].uu)
		else $error("active limits out of order");
	AST_PERIOD: assert property (@(posedge clk) disable iff (rst)
		s_ff.act[2].ra_per != 16'h0000 && s_ff.act[2].ra_per <= 16'h1770)
		else $error("active rate period out of range");
	AST_PERIOD_KEEP: assert property (@(posedge clk) disable iff (rst)
		cmt && !(|ch_run) && s_ff.pend[2].ra_per == 16'h0000 |=> s_ff.act[2].ra_per == $past(s_ff.act[2].ra_per))
		else $error("zero rate period was applied");
	AST_TRIM_KEEP: assert property (@(posedge clk) disable iff (rst)
		cmt && !(|ch_run) && s_ff.pend[0].trim > 16'sh1388 |=> s_ff.act[0].trim == $past(s_ff.act[0].trim))
		else $error("bad trim was applied");
	AST_TRIM_COPY: assert property (@(posedge clk) disable iff (rst)
		cmt && !(|ch_run) && s_ff.pend[2].trim >= TRIM_MIN && s_ff.pend[2].trim <= TRIM_MAX
		|=> s_ff.act[2].trim == $past(s_ff.pend[2].trim))
		else $error("valid trim not applied");
	AST_TGT_KEEP: assert property (@(posedge clk) disable iff (rst)
		cmt && !(|ch_run) && !s_ff.rng[2].dp && s_ff.pend[2].off_tgt > s_ff.rng[2].hi
		|=> s_ff.act[2].off_tgt == $past(s_ff.act[2].off_tgt))
		else $error("out-of-range offset target was applied");
	AST_RATE_COPY: assert property (@(posedge clk) disable iff (rst)
		cmt && !(|ch_run) |=> s_ff.act[2].ra_up == $past(s_ff.pend[2].ra_up)
		&& s_ff.act[2].ra_lo == $past(s_ff.pend[2].ra_lo))
		else $error("rate alarm limit not applied");
	AST_EN_COPY: assert property (@(posedge clk) disable iff (rst)
		cmt && !(|ch_run) |=> s_ff.act[2].ra_en == $past(s_ff.pend[2].ra_en)
		&& s_ff.act[2].pa_en == $past(s_ff.pend[2].pa_en))
		else $error("alarm enable not applied");
	AST_LIVE: assert property (@(posedge clk) disable iff (rst)
		live && s_ff.pend[2].trim >= TRIM_MIN && s_ff.pend[2].trim <= TRIM_MAX
		|=> s_ff.act[2].trim == $past(s_ff.pend[2].trim) && s_ff.ist[1])
		else $error("live change did not apply trim");
	AST_TRIM_ON: assert property (@(posedge clk) disable iff (rst)
		s_ff.func != 4'h0 |=> !trim_on_o)
		else $error("trim applied with two-point function");
	AST_OFF_PLAIN: assert property (@(posedge clk) disable iff (rst)
		meas_i.cap_off && meas_i.ch == 2'h0 && !s_ff.rng[0].dp |=> s_ff.pend[0].off_meas == $past(meas_i.process_value))
		else $error("offset point not stored as measured");
	AST_MEAS: assert property (@(posedge clk) disable iff (rst)
		meas_i.cap_off && meas_i.ch == 2'h1 && s_ff.rng[1].dp
		|=> s_ff.pend[1].off_meas == 16'($past(meas_i.process_value) * 16'sh000a))
		else $error("offset point not stored times ten");
	AST_GAIN_MEAS: assert property (@(posedge clk) disable iff (rst)
		meas_i.cap_gain && meas_i.ch == 2'h1 && s_ff.rng[1].dp
		|=> s_ff.pend[1].gain_meas == 16'($past(meas_i.process_value) * 16'sh000a))
		else $error("gain point not stored times ten");
	AST_ERR_CODE: assert property (@(posedge clk) disable iff (rst)
		$rose(s_ff.ist[0]) |-> s_ff.err == 16'h0004 || s_ff.err == 16'h0008)
		else $error("error flag without error code");
	AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (rst)
		s_ff.irq == |(s_ff.ist & s_ff.ien))
		else $error("interrupt output does not follow enabled status");

endmodule : acb_bank

// ### logic/acb_pkg.sv
// Register map, reset values and carrier types of the alarm/correction bank
package acb_pkg;

	// ----------------------------------------------------------------
	// Register word indexes (byte address = 4 * index)
	// ----------------------------------------------------------------
	localparam int         NCH                          = 4;
	localparam logic [9:0] IX_PROC_ALARM_ENABLE_CH1     = 10'h250;
	localparam logic [9:0] IX_PROC_ALARM_LOWER_LOWER    = 10'h251;
	localparam logic [9:0] IX_PROC_ALARM_LOWER_UPPER    = 10'h252;
	localparam logic [9:0] IX_PROC_ALARM_UPPER_LOWER    = 10'h253;
	localparam logic [9:0] IX_PROC_ALARM_UPPER_UPPER    = 10'h254;
	localparam logic [9:0] IX_RATE_ALARM_ENABLE         = 10'h255;
	localparam logic [9:0] IX_RATE_ALARM_PERIOD         = 10'h256;
	localparam logic [9:0] IX_RATE_ALARM_UPPER          = 10'h257;
	localparam logic [9:0] IX_RATE_ALARM_LOWER          = 10'h258;
	localparam logic [9:0] IX_PROC_ALARM_ENABLE_CH3     = 10'h262;
	localparam logic [9:0] IX_ALARM_STRIDE              = (IX_PROC_ALARM_ENABLE_CH3 - IX_PROC_ALARM_ENABLE_CH1) >> 1;
	localparam logic [9:0] IX_SENSOR_OFFSET_TRIM        = 10'h280;
	localparam logic [9:0] IX_TWO_POINT_OFFSET_MEASURED = 10'h284;
	localparam logic [9:0] IX_TWO_POINT_OFFSET_TARGET   = 10'h285;
	localparam logic [9:0] IX_TWO_POINT_GAIN_MEASURED   = 10'h286;
	localparam logic [9:0] IX_TWO_POINT_GAIN_TARGET     = 10'h287;
	localparam logic [9:0] IX_TWO_POINT_STRIDE          = 10'h004;
	localparam logic [9:0] IX_CTRL                      = 10'h300;
	localparam logic [9:0] IX_RUN                       = 10'h301;
	localparam logic [9:0] IX_DECIMAL                   = 10'h302;
	localparam logic [9:0] IX_CORR_FUNC                 = 10'h303;
	localparam logic [9:0] IX_LATEST_ERROR              = 10'h304;
	localparam logic [9:0] IX_IRQ_STATUS                = 10'h305;
	localparam logic [9:0] IX_IRQ_CLEAR                 = 10'h306;
	localparam logic [9:0] IX_IRQ_ENABLE                = 10'h307;
	localparam logic [9:0] IX_RANGE_LOW                 = 10'h310;
	localparam logic [9:0] IX_RANGE_HIGH                = 10'h314;

	// ----------------------------------------------------------------
	// Bit positions, codes and limits
	// ----------------------------------------------------------------
	localparam int                 CTRL_COMMIT      = 0;
	localparam int                 CTRL_LIVE        = 1;
	localparam int                 IRQ_ERROR        = 0;
	localparam int                 IRQ_DONE         = 1;
	localparam int                 IRQ_REFUSED      = 2;
	localparam int                 NIRQ             = 3;
	localparam logic [15:0]        ERR_WRITE_DATA   = 16'h0004;
	localparam logic [15:0]        ERR_OUT_OF_RANGE = 16'h0008;
	localparam logic [15:0]        RA_PERIOD_MIN    = 16'h0001;
	localparam logic [15:0]        RA_PERIOD_MAX    = 16'h1770;
	localparam logic signed [15:0] TRIM_MIN         = -16'sh1388;
	localparam logic signed [15:0] TRIM_MAX         = 16'sh1388;
	localparam logic signed [15:0] DP_MUL           = 16'sh000a;
	localparam logic [3:0]         FUNC_ONE_POINT   = 4'h0;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic               PA_EN_RST        = 1'b1;
	localparam logic               RA_EN_RST        = 1'b1;
	localparam logic [15:0]        RA_PERIOD_RST    = 16'h0001;
	localparam logic signed [15:0] PA_LOW_RST_A     = 16'sh0000;
	localparam logic signed [15:0] PA_HIGH_RST_A    = 16'sh0514;
	localparam logic signed [15:0] PA_LOW_RST_B     = -16'sh07d0;
	localparam logic signed [15:0] PA_HIGH_RST_B    = 16'sh1770;
	localparam logic signed [15:0] RANGE_LOW_RST    = -16'sh07d0;
	localparam logic signed [15:0] RANGE_HIGH_RST   = 16'sh1770;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [11:0] adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} acb_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} acb_wb_rsp_t;

	typedef struct packed {
		logic               cap_off;
		logic               cap_gain;
		logic [1:0]         ch;
		logic signed [15:0] process_value;
	} acb_meas_t;

	typedef struct packed {
		logic               pa_en;
		logic signed [15:0] ll;
		logic signed [15:0] lu;
		logic signed [15:0] ul;
		logic signed [15:0] uu;
		logic               ra_en;
		logic [15:0]        ra_per;
		logic signed [15:0] ra_up;
		logic signed [15:0] ra_lo;
		logic signed [15:0] trim;
		logic signed [15:0] off_meas;
		logic signed [15:0] off_tgt;
		logic signed [15:0] gain_meas;
		logic signed [15:0] gain_tgt;
	} acb_ch_t;

	typedef struct packed {
		logic               dp;
		logic signed [15:0] lo;
		logic signed [15:0] hi;
	} acb_rng_t;

	typedef struct packed {
		acb_ch_t [NCH-1:0]  pend;
		acb_ch_t [NCH-1:0]  act;
		acb_rng_t [NCH-1:0] rng;
		logic [1:0]         ctrl;
		logic [1:0]         ctrl_d;
		logic [3:0]         func;
		logic [15:0]        err;
		logic [NIRQ-1:0]    ist;
		logic [NIRQ-1:0]    ien;
		logic               ack;
		logic [15:0]        rdat;
		logic               trim_on;
		logic               irq;
	} acb_state_t;

endpackage : acb_pkg

// ### dv/acb_master_model.sv
// Wishbone classic master model standing in for the network master
`timescale 1ns/100ps
module acb_master_model
	import acb_pkg::*;
(
	input  wire logic        clk,
	output acb_wb_req_t      req,
	input  wire acb_wb_rsp_t rsp
);
	initial req = '0;

	// ----------------------------------------------------------------
	// Bus cycles
	// ----------------------------------------------------------------
	// Request held until ack is sampled; no latency assumed, the bench timeout cuts a hang
	task automatic xfer(input logic we, input logic [9:0] idx, input logic [15:0] wd, output logic [15:0] rd);
		@(posedge clk);
		req <= {1'b1, 1'b1, we, idx, 2'b00, 4'h3, 16'h0000, wd};
		@(posedge clk);
		while (rsp.ack !== 1'b1)
			@(posedge clk);
		rd = rsp.dat[15:0];
		req <= '0;
	endtask : xfer

	// Request bits are always taken low first so the device sees a clean rising edge
	task automatic pulse_ctrl(input int bitpos);
		logic [15:0] d;
		xfer(1'b1, IX_CTRL, 16'h0000, d);
		xfer(1'b1, IX_CTRL, 16'h0001 << bitpos, d);
	endtask : pulse_ctrl
endmodule : acb_master_model

// ### dv/alarm_correction_config_bank_tb_top.sv
// Self-checking bench for the alarm and correction configuration bank
`timescale 1ns/100ps
module alarm_correction_config_bank_tb_top import acb_pkg::*;;
	logic              clk;
	logic              rst;
	acb_wb_req_t       wb_req;
	acb_wb_rsp_t       wb_rsp;
	logic [NCH-1:0]    ch_run;
	acb_meas_t         meas;
	acb_ch_t [NCH-1:0] act;
	logic              trim_on;
	logic              irq;
	int                mismatches = 0;
	int                n_checks   = 0;
	int                cycles     = 0;
	logic [15:0]       rd;
	logic [9:0]        b;
	logic [15:0]       dflt [9] = '{16'h0001, 16'h0000, 16'h0000, 16'h0514, 16'h0514,
	                                16'h0001, 16'h0001, 16'h0000, 16'h0000};

	initial clk = 1'b0;
	always #25 clk = ~clk;

	acb_bank #(.WIDE_VARIANT(1'b0)) dut_u (.clk(clk), .rst(rst), .wb_i(wb_req), .wb_o(wb_rsp), .ch_run(ch_run),
		.meas_i(meas), .act_o(act), .trim_on_o(trim_on), .irq_o(irq));
	acb_master_model mst_u (.clk(clk), .req(wb_req), .rsp(wb_rsp));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic test_done();
		if (mismatches == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [9:0] idx, input logic [15:0] d);
		logic [15:0] unused;
		mst_u.xfer(1'b1, idx, d, unused);
	endtask : wr

	task automatic rdchk(input string name, input logic [9:0] idx, input logic [15:0] exp);
		mst_u.xfer(1'b0, idx, 16'h0000, rd);
		chk(name, exp, rd);
	endtask : rdchk

	// Active settings land on the edge where the master samples the ack; three more edges leave them settled
	task automatic commit(input int bitpos);
		mst_u.pulse_ctrl(bitpos);
		repeat (3) @(posedge clk);
	endtask : commit

	task automatic capture(input logic off, input logic [1:0] ch, input logic [15:0] value);
		@(posedge clk);
		meas <= {off, ~off, ch, value};
		@(posedge clk);
		meas <= '0;
		repeat (2) @(posedge clk);
	endtask : capture

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			test_done();
		end
	end

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		ch_run = '0;
		meas = '0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (int n = 0; n < NCH; n++) begin
			b = IX_PROC_ALARM_ENABLE_CH1 + IX_ALARM_STRIDE * 10'(n);
			for (int k = 0; k < 9; k++)
				rdchk("alarm word", b + 10'(k), dflt[k]);
			rdchk("trim", IX_SENSOR_OFFSET_TRIM + 10'(n), 16'h0000);
			rdchk("offset target", IX_TWO_POINT_OFFSET_TARGET + IX_TWO_POINT_STRIDE * 10'(n), 16'h0000);
		end
		rdchk("unmapped", 10'h3ff, 16'h0000);
		wr(IX_PROC_ALARM_ENABLE_CH3, 16'h0000);
		wr(IX_PROC_ALARM_LOWER_LOWER + 10'd18, 16'hfff6);
		wr(IX_PROC_ALARM_LOWER_UPPER + 10'd18, 16'h0000);
		wr(IX_PROC_ALARM_UPPER_LOWER + 10'd18, 16'h0064);
		wr(IX_PROC_ALARM_UPPER_UPPER + 10'd18, 16'h1770);
		commit(0);
		chk("act pa_en", 16'h0000, {15'h0000, act[2].pa_en});
		chk("act ll", 16'hfff6, act[2].ll);
		chk("act uu", 16'h1770, act[2].uu);
		rdchk("status", IX_IRQ_STATUS, 16'h0002);
		wr(IX_IRQ_CLEAR, 16'h0007);
		wr(IX_PROC_ALARM_LOWER_UPPER + 10'd18, 16'h00c8);
		commit(0);
		chk("act lu kept", 16'h0000, act[2].lu);
		rdchk("error word", IX_LATEST_ERROR, ERR_OUT_OF_RANGE);
		rdchk("status", IX_IRQ_STATUS, 16'h0003);
		wr(IX_PROC_ALARM_LOWER_UPPER + 10'd18, 16'h0000);
		wr(IX_RATE_ALARM_PERIOD + 10'd18, 16'h0000);
		commit(0);
		chk("act period kept", 16'h0001, act[2].ra_per);
		rdchk("error word", IX_LATEST_ERROR, ERR_WRITE_DATA);
		wr(IX_RATE_ALARM_PERIOD + 10'd18, 16'h1770);
		wr(IX_PROC_ALARM_UPPER_UPPER + 10'd18, 16'h1771);
		commit(0);
		chk("act period", 16'h1770, act[2].ra_per);
		chk("act uu kept", 16'h1770, act[2].uu);
		rdchk("error word", IX_LATEST_ERROR, ERR_OUT_OF_RANGE);
		wr(IX_PROC_ALARM_UPPER_UPPER + 10'd18, 16'h1770);
		wr(IX_SENSOR_OFFSET_TRIM + 10'd2, 16'h1389);
		wr(IX_TWO_POINT_OFFSET_TARGET + 10'd8, 16'h1771);
		commit(0);
		chk("act trim kept", 16'h0000, act[2].trim);
		chk("act target kept", 16'h0000, act[2].off_tgt);
		rdchk("error word", IX_LATEST_ERROR, ERR_WRITE_DATA);
		wr(IX_SENSOR_OFFSET_TRIM + 10'd2, 16'hec78);
		wr(IX_TWO_POINT_OFFSET_TARGET + 10'd8, 16'h1770);
		wr(IX_RATE_ALARM_UPPER + 10'd18, 16'h8000);
		wr(IX_RATE_ALARM_LOWER + 10'd18, 16'h7fff);
		commit(0);
		chk("act trim", 16'hec78, act[2].trim);
		chk("act target", 16'h1770, act[2].off_tgt);
		chk("act rate upper", 16'h8000, act[2].ra_up);
		chk("act rate lower", 16'h7fff, act[2].ra_lo);
		wr(IX_IRQ_CLEAR, 16'h0007);
		ch_run <= 4'h1;
		wr(IX_RATE_ALARM_UPPER + 10'd18, 16'h0005);
		commit(0);
		chk("act rate upper held", 16'h8000, act[2].ra_up);
		rdchk("status", IX_IRQ_STATUS, 16'h0004);
		wr(IX_SENSOR_OFFSET_TRIM + 10'd2, 16'h0064);
		commit(1);
		chk("act trim live", 16'h0064, act[2].trim);
		chk("act rate upper live", 16'h8000, act[2].ra_up);
		ch_run <= 4'h0;
		wr(IX_CORR_FUNC, 16'h0001);
		repeat (3) @(posedge clk);
		chk("trim on", 16'h0000, {15'h0000, trim_on});
		wr(IX_CORR_FUNC, 16'h0000);
		repeat (3) @(posedge clk);
		chk("trim on", 16'h0001, {15'h0000, trim_on});
		capture(1'b1, 2'd0, 16'h0019);
		rdchk("offset measured", IX_TWO_POINT_OFFSET_MEASURED, 16'h0019);
		wr(IX_DECIMAL, 16'h0002);
		capture(1'b1, 2'd1, 16'h0007);
		rdchk("offset measured", IX_TWO_POINT_OFFSET_MEASURED + 10'd4, 16'h0046);
		capture(1'b0, 2'd1, 16'hfffd);
		rdchk("gain measured", IX_TWO_POINT_GAIN_MEASURED + 10'd4, 16'hffe2);
		wr(IX_IRQ_CLEAR, 16'h0007);
		wr(IX_IRQ_ENABLE, 16'h0001);
		wr(IX_SENSOR_OFFSET_TRIM, 16'h1389);
		commit(0);
		chk("irq raised", 16'h0001, {15'h0000, irq});
		wr(IX_IRQ_ENABLE, 16'h0000);
		repeat (3) @(posedge clk);
		chk("irq masked", 16'h0000, {15'h0000, irq});
		wr(IX_IRQ_ENABLE, 16'h0001);
		wr(IX_IRQ_CLEAR, 16'h0001);
		repeat (3) @(posedge clk);
		chk("irq cleared", 16'h0000, {15'h0000, irq});
		test_done();
	end
endmodule : alarm_correction_config_bank_tb_top
